// File: design/ext_bus_regs.svh
// register offsets, field positions, reset values and counts of the external bus control block
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ************
// register offsets
// ************
`define OFS_PROC_MODE 5'h00
`define OFS_BUS_CTRL  5'h04
`define OFS_ACC_ADDR  5'h08
`define OFS_ACC_DATA  5'h0c
`define OFS_ACC_CMD   5'h10
`define OFS_STATUS    5'h14

// ************
// field positions
// ************
`define PM_CLKDIS_BIT   0
`define PM_MPMC_BIT     1
`define BC_WS_LSB       0
`define BC_WS_MSB       3
`define BC_OWNER_BIT    4
`define BC_GP3_LVL_BIT  5
`define BC_GP3_DRV_BIT  6
`define BC_TOUT_BIT     7
`define BC_HRDY_BIT     8
`define BC_OSC_TEST_BIT 9
`define BC_WIDTH        10
`define AA_SPACE_LSB    16
`define AA_SPACE_MSB    17
`define AA_DMA_BIT      18
`define CMD_GO_BIT      0
`define CMD_WR_BIT      1
`define ST_BUSY_BIT     0
`define ST_REFUSED_BIT  1

// ************
// reset values and counts
// ************
`define BUS_CTRL_RST   10'h002
`define READY_MIN_WS   4'h2
`define MCLK_DIV_DEF   4
`define MPMC_TABLE_DEF 8'h0f
`define SETTLE_CYCLES  3'h5
`endif

// File: design/ext_bus_pkg.sv
// types shared by the external bus control block
package ext_bus_pkg;
  // external address space of an access
  typedef enum logic [1:0] {
    SPACE_PROG = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_IO   = 2'h2
  } space_t;
  // external access sequence
  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_END} acc_state_t;
endpackage

// File: design/pin_sync_if.sv
// raw pin levels in, filtered levels out, between the block and its pin conditioner
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport conditioner (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// File: design/pin_conditioner.sv
// three-flop synchroniser with agreement filter for asynchronous pin inputs
`timescale 1ns/1ps
module pin_conditioner #(
  parameter int WIDTH = 1
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  pin_sync_if.conditioner    pins
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ************
  // synchroniser chain
  // ************
  // stage1 may go metastable, so only stage2 looks at it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only where the second and third flops agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins.clean <= {WIDTH{1'b0}};
    end else begin
      pins.clean <= (stage2 & stage3) | (pins.clean & (stage2 | stage3));
    end
  end
endmodule

// File: design/ext_bus_control.sv
// external parallel port control: memory/io access sequencing, pin reuse and machine clock output
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module ext_bus_control import ext_bus_pkg::*; #(
  parameter int       ADDR_W     = 16,
  parameter int       DATA_W     = 16,
  parameter int       MCLK_DIV   = `MCLK_DIV_DEF,
  parameter bit [7:0] MPMC_TABLE = `MPMC_TABLE_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [4:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  output logic      [ADDR_W-1:0] ext_addr,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_in,
  output logic                   rw_out,
  output logic                   rw_oe,
  input  wire logic              rw_in,
  output logic                   io_space_strobe_n_out,
  output logic                   io_space_strobe_n_oe,
  input  wire logic              io_space_strobe_n_in,
  output logic                   program_space_sel_n,
  output logic                   data_space_sel_n,
  output logic                   memory_strobe_n,
  output logic                   space_sel_oe,
  input  wire logic              ready_in,
  output logic                   ready_out,
  output logic                   ready_oe,
  input  wire logic              emu_float_n,
  input  wire logic              port_mode_select,
  input  wire logic              host_mux_mode,
  input  wire logic              subsystem_select,
  input  wire logic              timer_out_a,
  output logic                   host_port_target_b,
  output logic                   machine_clock_out,
  output logic                   machine_clock_oe,
  output logic                   osc_stage_out,
  output logic                   osc_stage_oe
);
  localparam int SYNC_W = DATA_W + 7;
  localparam int DIV_W  = $clog2(MCLK_DIV);
  localparam logic [DIV_W-1:0] PHASE_LAST = DIV_W'(MCLK_DIV - 1);
  localparam logic [DIV_W-1:0] PHASE_RISE = DIV_W'(MCLK_DIV / 2 - 1);

  // ************
  // elaboration checks
  // ************
  if (MCLK_DIV < 2 || (MCLK_DIV % 2) != 0) begin : g_bad_div
    $error("machine clock divider must be even and at least 2");
  end
  if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1 || DATA_W > 16) begin : g_bad_width
    $error("address and data widths must lie between 1 and 16");
  end

  // ************
  // pin conditioning
  // ************
  logic [DATA_W-1:0] data_s;
  logic              ready_s;
  logic              host_dir_s;
  logic              gp3_s;
  logic              float_n_s;
  logic              mem_mode_s;
  logic              host_mux_mode_s;
  logic              select_s;
  pin_sync_if #(.WIDTH(SYNC_W)) pin_bus ();

  // all asynchronous pins share one conditioner
  assign pin_bus.raw = {data_in, ready_in, rw_in, io_space_strobe_n_in, emu_float_n,
                        port_mode_select, host_mux_mode, subsystem_select};
  assign {data_s, ready_s, host_dir_s, gp3_s, float_n_s, mem_mode_s, host_mux_mode_s, select_s} = pin_bus.clean;

  pin_conditioner #(.WIDTH(SYNC_W)) u_cond (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pins    (pin_bus)
  );

  // ************
  // register state
  // ************
  logic                   clk_dis;
  logic                   mpmc;
  logic [`BC_WIDTH-1:0]   bus_ctrl;
  logic [ADDR_W-1:0]      acc_addr;
  space_t                 acc_space;
  logic                   acc_dma;
  logic [DATA_W-1:0]      acc_wdata;
  logic [DATA_W-1:0]      acc_rdata;
  logic                   refused;
  logic [2:0]             settle_cnt;
  acc_state_t             acc_state;
  logic [3:0]             wait_cnt;
  logic [3:0]             acc_ws;
  logic                   acc_wr;
  space_t                 pin_space;
  logic [DIV_W-1:0]       phase_cnt;
  logic                   mc_tick;
  logic [31:0]            wmask;
  logic [31:0]            rd_mux;
  logic                   wr_en;
  logic                   go_req;
  logic                   go_ok;
  logic                   ws_ready;
  logic                   active;

  // byte enables become a bit mask for partial writes
  assign wmask  = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wr_en  = write & ~waitrequest;
  assign go_req = wr_en && address == `OFS_ACC_CMD && byteenable[0] && writedata[`CMD_GO_BIT];
  // an access is started only when the port is ours and the request is legal
  assign go_ok  = go_req && acc_state == ST_IDLE && mem_mode_s
                  && select_s == bus_ctrl[`BC_OWNER_BIT]
                  && acc_space != 2'h3 && !(acc_dma && acc_space == SPACE_IO);
  assign ws_ready = acc_ws >= `READY_MIN_WS;
  assign active   = acc_state != ST_IDLE;

  // ************
  // avalon slave handshake
  // ************
  // one wait cycle per request gives a registered answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if ((read | write) & ~waitrequest) begin
      waitrequest <= 1'b1;
    end else if (read | write) begin
      waitrequest <= 1'b0;
    end
  end

  // read mux; unmapped offsets and the command register read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (address)
      `OFS_PROC_MODE: begin
        rd_mux[`PM_CLKDIS_BIT] = clk_dis;
        rd_mux[`PM_MPMC_BIT]   = mpmc;
      end
      `OFS_BUS_CTRL: rd_mux[`BC_WIDTH-1:0] = bus_ctrl;
      `OFS_ACC_ADDR: begin
        rd_mux[ADDR_W-1:0]                     = acc_addr;
        rd_mux[`AA_SPACE_MSB:`AA_SPACE_LSB]    = acc_space;
        rd_mux[`AA_DMA_BIT]                    = acc_dma;
      end
      `OFS_ACC_DATA: rd_mux[DATA_W-1:0] = acc_rdata;
      `OFS_STATUS: rd_mux[8:0] = {float_n_s, gp3_s, ready_s, host_mux_mode_s, host_dir_s, select_s,
                                  mem_mode_s, refused, active};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & waitrequest) begin
      readdata <= rd_mux;
    end
  end

  // ************
  // software registers
  // ************
  // mode status: clock disable is writable, mode bit is read only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_dis <= 1'b0;
    end else if (wr_en && address == `OFS_PROC_MODE && byteenable[0]) begin
      clk_dis <= writedata[`PM_CLKDIS_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_ctrl <= `BUS_CTRL_RST;
    end else if (wr_en && address == `OFS_BUS_CTRL) begin
      bus_ctrl <= (bus_ctrl & ~wmask[`BC_WIDTH-1:0]) | (writedata[`BC_WIDTH-1:0] & wmask[`BC_WIDTH-1:0]);
    end
  end

  // access address and space; the pins take their own copy at start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_addr  <= {ADDR_W{1'b0}};
      acc_space <= SPACE_PROG;
      acc_dma   <= 1'b0;
    end else if (wr_en && address == `OFS_ACC_ADDR) begin
      acc_addr  <= (acc_addr & ~wmask[ADDR_W-1:0]) | (writedata[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
      if (byteenable[2]) begin
        acc_space <= space_t'(writedata[`AA_SPACE_MSB:`AA_SPACE_LSB]);
        acc_dma   <= writedata[`AA_DMA_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_wdata <= {DATA_W{1'b0}};
    end else if (wr_en && address == `OFS_ACC_DATA) begin
      acc_wdata <= (acc_wdata & ~wmask[DATA_W-1:0]) | (writedata[DATA_W-1:0] & wmask[DATA_W-1:0]);
    end
  end

  // refusal flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      refused <= 1'b0;
    end else if (go_req && !go_ok) begin
      refused <= 1'b1;
    end else if (wr_en && address == `OFS_STATUS && byteenable[0] && writedata[`ST_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // ************
  // reset-time mode capture
  // ************
  // pins are read only once the conditioner has filled, never inside the reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      settle_cnt <= 3'h0;
      mpmc       <= 1'b0;
    end else if (settle_cnt != `SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 3'h1;
      if (settle_cnt == `SETTLE_CYCLES - 3'h1) begin
        mpmc <= MPMC_TABLE[{mem_mode_s, host_mux_mode_s, select_s}];
      end
    end
  end

  // ************
  // machine clock
  // ************
  assign mc_tick = phase_cnt == PHASE_LAST;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_cnt <= {DIV_W{1'b0}};
    end else if (mc_tick) begin
      phase_cnt <= {DIV_W{1'b0}};
    end else begin
      phase_cnt <= phase_cnt + DIV_W'(1);
    end
  end

  // falls on every cycle boundary; disable freezes it where it stands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      machine_clock_out <= 1'b0;
    end else if (!clk_dis) begin
      if (mc_tick) begin
        machine_clock_out <= 1'b0;
      end else if (phase_cnt == PHASE_RISE) begin
        machine_clock_out <= 1'b1;
      end
    end
  end

  // clock float and oscillator stage test drive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      machine_clock_oe <= 1'b0;
      osc_stage_out    <= 1'b0;
      osc_stage_oe     <= 1'b0;
    end else begin
      machine_clock_oe <= float_n_s;
      osc_stage_out    <= machine_clock_out;
      osc_stage_oe     <= bus_ctrl[`BC_OSC_TEST_BIT];
    end
  end

  // ************
  // access sequencer
  // ************
  // leaves idle as soon as the go command is accepted, then steps only on machine cycle boundaries; a switch to host mode abandons the access
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_state <= ST_IDLE;
      wait_cnt  <= 4'h0;
      acc_ws    <= 4'h0;
      acc_wr    <= 1'b0;
    end else if (active && !mem_mode_s) begin
      acc_state <= ST_IDLE;
    end else begin
      unique case (acc_state)
        ST_IDLE: if (go_ok) begin
          acc_state <= ST_SETUP;
          acc_ws    <= bus_ctrl[`BC_WS_MSB:`BC_WS_LSB];
          acc_wr    <= writedata[`CMD_WR_BIT];
        end
        ST_SETUP: if (mc_tick) begin
          acc_state <= ST_STROBE;
          wait_cnt  <= acc_ws;
        end
        ST_STROBE: if (mc_tick) begin
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (!(ws_ready && !ready_s)) begin
            acc_state <= ST_END;
          end
        end
        ST_END: if (mc_tick) begin
          acc_state <= ST_IDLE;
        end
      endcase
    end
  end

  // read data taken on the closing boundary of the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_rdata <= {DATA_W{1'b0}};
    end else if (acc_state == ST_STROBE && mc_tick && wait_cnt == 4'h0 && !acc_wr
                 && !(ws_ready && !ready_s)) begin
      acc_rdata <= data_s;
    end
  end

  // ************
  // external pins
  // ************
  // address, space and write data latched once per access and held to its end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_addr  <= {ADDR_W{1'b0}};
      pin_space <= SPACE_PROG;
      data_out  <= {DATA_W{1'b0}};
    end else if (go_ok) begin
      ext_addr  <= acc_addr;
      pin_space <= acc_space;
      data_out  <= acc_wdata;
    end
  end

  // memory-side strobes, selects and direction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      program_space_sel_n <= 1'b1;
      data_space_sel_n    <= 1'b1;
      memory_strobe_n     <= 1'b1;
      space_sel_oe        <= 1'b0;
      rw_out              <= 1'b1;
      rw_oe               <= 1'b0;
      data_oe             <= 1'b0;
    end else begin
      program_space_sel_n <= !(active && pin_space == SPACE_PROG);
      data_space_sel_n    <= !(active && pin_space == SPACE_DATA);
      memory_strobe_n     <= !(acc_state == ST_STROBE && pin_space != SPACE_IO && mem_mode_s);
      space_sel_oe        <= float_n_s && mem_mode_s;
      rw_out              <= !(active && acc_wr);
      rw_oe               <= float_n_s && mem_mode_s;
      data_oe             <= float_n_s && mem_mode_s && active && acc_wr;
    end
  end

  // io strobe pin: strobe in memory mode, gp pin 3 or timer in host mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      io_space_strobe_n_out <= 1'b1;
      io_space_strobe_n_oe  <= 1'b0;
    end else if (mem_mode_s) begin
      io_space_strobe_n_out <= !(acc_state == ST_STROBE && pin_space == SPACE_IO);
      io_space_strobe_n_oe  <= float_n_s;
    end else begin
      io_space_strobe_n_out <= bus_ctrl[`BC_TOUT_BIT] ? timer_out_a : bus_ctrl[`BC_GP3_LVL_BIT];
      io_space_strobe_n_oe  <= float_n_s && (bus_ctrl[`BC_TOUT_BIT] || bus_ctrl[`BC_GP3_DRV_BIT]);
    end
  end

  // ready pin turns into host data ready output in host mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_out          <= 1'b0;
      ready_oe           <= 1'b0;
      host_port_target_b <= 1'b0;
    end else begin
      ready_out          <= bus_ctrl[`BC_HRDY_BIT];
      ready_oe           <= !mem_mode_s;
      host_port_target_b <= select_s;
    end
  end

  // ************
  // assertions
  // ************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_last_wait;
    acc_state == ST_STROBE && mc_tick && wait_cnt == 4'h0 && mem_mode_s;
  endsequence
  sequence s_start;
    acc_state == ST_IDLE ##1 acc_state == ST_SETUP;
  endsequence

  a_ready_extends: assert property (s_last_wait and (ws_ready && !ready_s) |=>
    acc_state == ST_STROBE && $stable(ext_addr)) else $error("ready low did not extend access");
  a_ready_ignored: assert property (s_last_wait and !ws_ready |=> acc_state == ST_END)
    else $error("ready examined below two wait states");
  a_rw_rests_high: assert property ($past(acc_state) == ST_IDLE |-> rw_out)
    else $error("read/write low outside a write");
  a_float_pins: assert property (!float_n_s |=> !rw_oe && !io_space_strobe_n_oe && !machine_clock_oe)
    else $error("pin driven while float input low");
  a_io_strobe_space: assert property (!io_space_strobe_n_out && $past(mem_mode_s) |->
    $past(pin_space) == SPACE_IO) else $error("io strobe on a memory access");
  a_dma_io_refused: assert property (go_req && acc_state == ST_IDLE && acc_dma && acc_space == SPACE_IO |=>
    acc_state == ST_IDLE && refused) else $error("dma reached external io space");
  a_owner_granted: assert property (s_start |-> $past(select_s) == $past(bus_ctrl[`BC_OWNER_BIT]))
    else $error("access started without owning the port");
  a_host_ready_out: assert property (!mem_mode_s |=> ready_oe ##1 ready_oe || mem_mode_s)
    else $error("ready pin not driven in host mode");
  a_host_rw_input: assert property (!mem_mode_s |=> !rw_oe)
    else $error("read/write driven in host mode");
  a_mode_capture: assert property (settle_cnt == `SETTLE_CYCLES - 3'h1 |=>
    mpmc == MPMC_TABLE[$past({mem_mode_s, host_mux_mode_s, select_s})]) else $error("mode bit not captured");
  a_clock_fall_edge: assert property ($fell(machine_clock_out) |-> $past(mc_tick))
    else $error("clock fell off a cycle boundary");
  a_clock_frozen: assert property (clk_dis [*2] |-> $stable(machine_clock_out))
    else $error("clock toggled while disabled");
  a_osc_floats: assert property (!bus_ctrl[`BC_OSC_TEST_BIT] |=> !osc_stage_oe)
    else $error("oscillator stage driven outside test");
  a_strobe_mem_mode: assert property (!memory_strobe_n |-> $past(mem_mode_s))
    else $error("memory strobe outside memory mode");
  a_addr_held: assert property (active && $past(active) |-> $stable(ext_addr) && $stable(pin_space))
    else $error("address moved during an access");
endmodule

// File: verification/ext_mem_model.sv
// external memory and io device model answering the port's strobes
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        strobe_n,
  input  wire logic [3:0]  slow,
  output logic             ready,
  output logic [15:0]      rdata
);
  int cnt = 0;
  initial rdata = 16'h0f0f;
  // count cycles since the strobe fell; a slow device answers late
  always @(posedge sys_clk) cnt <= strobe_n ? 0 : cnt + 1;
  assign ready = !strobe_n && cnt >= slow;
  // released bus toggles each cycle, so after a strobe it shows the read value 16'hbe5a again on every other cycle
  always @(posedge sys_clk) rdata <= strobe_n ? ~rdata : 16'hbe5a;
endmodule

// File: verification/external_bus_control_tb_top.sv
// self-checking bench for the external bus control block
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module external_bus_control_tb_top;
  logic sys_clk, rst, read, write, rw_in, emu_float_n, port_mode_select, host_mux_mode;
  logic subsystem_select, timer_out_a, ready_in, waitrequest, data_oe, rw_out, rw_oe, ready_out, ready_oe;
  logic io_space_strobe_n_out, io_space_strobe_n_oe, program_space_sel_n, data_space_sel_n;
  logic memory_strobe_n, space_sel_oe, host_port_target_b, machine_clock_out, machine_clock_oe;
  logic osc_stage_out, osc_stage_oe;
  logic [4:0]  address, seen;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable, slow;
  logic [15:0] ext_addr, data_out, data_in;
  int          len, bad_count, checks;
  ext_bus_control uut (.sys_clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .ext_addr, .data_out, .data_oe, .data_in, .rw_out, .rw_oe, .rw_in, .io_space_strobe_n_out,
    .io_space_strobe_n_oe, .io_space_strobe_n_in(io_space_strobe_n_out), .program_space_sel_n,
    .data_space_sel_n, .memory_strobe_n, .space_sel_oe, .ready_in, .ready_out, .ready_oe, .emu_float_n,
    .port_mode_select, .host_mux_mode, .subsystem_select, .timer_out_a, .host_port_target_b,
    .machine_clock_out, .machine_clock_oe, .osc_stage_out, .osc_stage_oe);
  ext_mem_model mem (.sys_clk, .strobe_n(memory_strobe_n & io_space_strobe_n_out), .slow,
    .ready(ready_in), .rdata(data_in));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  // pin picture and strobe length of the latest access
  always @(posedge sys_clk)
    if (memory_strobe_n === 1'b0 || io_space_strobe_n_out === 1'b0) begin
      len <= len + 1;
      seen <= {rw_out, program_space_sel_n, data_space_sel_n, memory_strobe_n, io_space_strobe_n_out};
    end
  // ************
  // tasks
  // ************
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    {read, write, address, writedata} <= {!wr, wr, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd = readdata;
    {read, write} <= 2'b00;
    if (n >= 40) begin
      bad_count++;
      results();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // external access: space with dma bit, direction, bus control, device delay, strobe length
  task automatic acc(input logic [2:0] sp, input logic wr, input logic [9:0] bc, input logic [3:0] s,
                     input int exp_len);
    int n = 0;
    slow <= s;
    bus(1, `OFS_BUS_CTRL, bc);
    bus(1, `OFS_ACC_ADDR, {sp, 16'h1234});
    bus(1, `OFS_ACC_DATA, 32'h5a5a);
    len = 0;
    bus(1, `OFS_ACC_CMD, {wr, 1'b1});
    do begin
      bus(0, `OFS_STATUS, 0);
      n++;
    end while (rd[`ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      bad_count++;
      results();
    end
    if (exp_len >= 0) chk(len, exp_len);
  endtask
  // machine clock transitions over 16 system cycles
  task automatic edges(input int exp);
    int n = 0;
    logic p = machine_clock_out;
    repeat (16) begin
      @(posedge sys_clk);
      if (machine_clock_out !== p) n++;
      p = machine_clock_out;
    end
    chk(n, exp);
  endtask
  // ************
  // main sequence
  // ************
  initial begin
    {rst, read, write, rw_in, emu_float_n, port_mode_select, host_mux_mode, subsystem_select, timer_out_a} = 9'h118;
    {address, writedata, slow, byteenable} = {41'h0, 4'hf};
    tick(5);
    rst <= 0;
    // filtered pins and the reset-time mode bit need a few edges to settle
    tick(8);
    bus(0, `OFS_PROC_MODE, 0);
    chk(rd[`PM_MPMC_BIT], (`MPMC_TABLE_DEF >> 4) & 8'h01);
    chk({rw_out, rw_oe, machine_clock_oe, osc_stage_oe}, 4'b1110);
    acc(3'h0, 1, 10'h000, 0, 4);
    chk(seen, 5'b00101);
    chk({ext_addr, data_out}, 32'h1234_5a5a);
    acc(3'h1, 0, 10'h001, 10, 8);
    chk(seen, 5'b11001);
    bus(0, `OFS_ACC_DATA, 0);
    chk(rd[15:0], 16'hbe5a);
    acc(3'h2, 0, 10'h002, 0, 12);
    chk(seen, 5'b11110);
    acc(3'h2, 1, 10'h002, 10, -1);
    chk(len > 12, 1);
    acc(3'h6, 0, 10'h000, 0, 0);
    chk(rd[`ST_REFUSED_BIT], 1);
    bus(1, `OFS_STATUS, 2);
    subsystem_select <= 1;
    tick(8);
    chk(host_port_target_b, 1);
    acc(3'h0, 0, 10'h000, 0, 0);
    bus(1, `OFS_STATUS, 2);
    acc(3'h0, 0, 10'h010, 0, 4);
    emu_float_n <= 0;
    tick(8);
    chk({rw_oe, io_space_strobe_n_oe, machine_clock_oe, space_sel_oe}, 0);
    emu_float_n <= 1;
    tick(8);
    edges(8);
    bus(1, `OFS_PROC_MODE, 1);
    // the write lands on the last bus edge; the clock may still move on that edge
    tick(1);
    edges(0);
    {port_mode_select, timer_out_a, rw_in} <= 3'b011;
    tick(8);
    bus(1, `OFS_BUS_CTRL, 10'h382);
    tick(2);
    chk({ready_oe, ready_out, rw_oe, io_space_strobe_n_out, osc_stage_oe, space_sel_oe}, 6'h36);
    chk(osc_stage_out, machine_clock_out);
    bus(0, `OFS_STATUS, 0);
    chk(rd[4], 1);
    results();
  end
endmodule
